//--- design/uam_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "uam_map.svh"

module uam_top (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic rxd_i,
    output logic txd_o,
    input wire logic txc_service_i
);

uam_pkg::uam_state_t s;
uam_pkg::uam_state_t next_s;
logic [2:0] char_size;
logic nine_bit;
logic [3:0] data_bits;
logic [4:0] spb;
logic [8:0] size_mask;
logic par_en;
logic par_odd;
logic addr_ok;
logic acc;
logic [7:0] wbyte;
logic [7:0] rd_byte;
logic samp_start;
logic vote_stb;
logic vote;
logic frame_type;
logic rx_par_calc;
logic tx_par;
logic [12:0] tx_frame;

// one size for rx and tx
assign char_size = {s.size_hi, s.frame_cfg[`UAM_FC_SIZE_HI:`UAM_FC_SIZE_LO]};
assign nine_bit = (char_size == `UAM_RST_NINE_CODE);
// reserved size codes behave as eight bits
assign data_bits = nine_bit ? 4'h9 : (char_size[2] ? 4'h8 : 4'({2'h0, char_size[1:0]} + 4'h5));
assign spb = s.double_speed_sel ? `UAM_SPB_DBL : `UAM_SPB_NORM;
assign size_mask = 9'(9'h1FF >> (4'h9 - data_bits));
assign par_en = s.frame_cfg[`UAM_FC_PAR_EN];
assign par_odd = s.frame_cfg[`UAM_FC_PAR_ODD];
assign rx_par_calc = (^(s.rx_shift & size_mask)) ^ par_odd;
assign tx_par = (^(s.tx_buf & size_mask)) ^ par_odd;

assign acc = psel_i & penable_i;
assign wbyte = pwdata_i[7:0];
assign addr_ok = (paddr_i == `UAM_OFS_CSA) || (paddr_i == `UAM_OFS_CSB) || (paddr_i == `UAM_OFS_SHARED)
    || (paddr_i == `UAM_OFS_BAUD_LO) || (paddr_i == `UAM_OFS_DATA);

uam_rx_sampler u_sampler (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .tick_i(s.tick),
    .start_i(samp_start),
    .double_speed_i(s.double_speed_sel),
    .rxd_i(s.rxd_sync),
    .vote_stb_o(vote_stb),
    .vote_o(vote)
);

// frame image, start bit first
always_comb
begin
    tx_frame = '1;
    tx_frame[0] = 1'b0;
    for (int i = 0; i < 9; i++)
    begin
        if (i < int'(data_bits))
        begin
            tx_frame[i + 1] = s.tx_buf[i];
        end
    end
    if (par_en)
    begin
        tx_frame[data_bits + 4'h1] = tx_par;
    end
end

// read data, captured in the setup cycle
always_comb
begin
    rd_byte = 8'h00;
    unique case (paddr_i)
        `UAM_OFS_CSA:
        begin
            rd_byte = {s.rx_complete_flag, s.tx_complete_flag, ~s.tx_full, s.frm_err, s.overrun, s.par_err,
                s.double_speed_sel, s.addr_filter_en};
        end
        `UAM_OFS_CSB:
        begin
            rd_byte = {s.rxie, s.txie, s.emptyie, s.rx_en, s.tx_en, s.size_hi, s.rx_buf[8], s.tx_ninth_bit};
        end
        `UAM_OFS_SHARED:
        begin
            if (s.shared_rd_prev)
            begin
                rd_byte = {1'b1, s.frame_cfg};
            end
            else
            begin
                rd_byte = {4'h0, s.baud_div_high};
            end
        end
        `UAM_OFS_BAUD_LO:
        begin
            rd_byte = s.baud_low;
        end
        `UAM_OFS_DATA:
        begin
            rd_byte = s.rx_buf[7:0];
        end
        default:
        begin
            rd_byte = 8'h00;
        end
    endcase
end

always_comb
begin
    next_s = s;
    samp_start = 1'b0;
    frame_type = 1'b0;
    // rx pin is asynchronous: two flops before use
    next_s.rxd_meta = rxd_i;
    next_s.rxd_sync = s.rxd_meta;

    // sample-rate tick from the 12-bit divisor
    next_s.tick = 1'b0;
    if (s.baud_cnt == 12'h000)
    begin
        next_s.baud_cnt = {s.baud_div_high, s.baud_low};
        next_s.tick = 1'b1;
    end
    else
    begin
        next_s.baud_cnt = 12'(s.baud_cnt - 12'h001);
    end

    // bus: read data registered at setup so it is stable in the access cycle
    if (psel_i && !penable_i && !pwrite_i)
    begin
        next_s.prdata = {24'h000000, rd_byte};
    end
    // a pair counts as back to back only with no idle cycle between
    if (acc && !pwrite_i && paddr_i == `UAM_OFS_SHARED)
    begin
        next_s.shared_rd_prev = 1'b1;
    end
    else if (acc || !psel_i)
    begin
        next_s.shared_rd_prev = 1'b0;
    end

    if (acc && pwrite_i)
    begin
        unique case (paddr_i)
            `UAM_OFS_CSA:
            begin
                if (wbyte[`UAM_A_TX_DONE])
                begin
                    next_s.tx_complete_flag = 1'b0;
                end
                next_s.double_speed_sel = wbyte[`UAM_A_DBL];
                next_s.addr_filter_en = wbyte[`UAM_A_FILTER];
            end
            `UAM_OFS_CSB:
            begin
                next_s.rxie = wbyte[`UAM_B_RXIE];
                next_s.txie = wbyte[`UAM_B_TXIE];
                next_s.emptyie = wbyte[`UAM_B_EMPTYIE];
                next_s.rx_en = wbyte[`UAM_B_RX_EN];
                next_s.tx_en = wbyte[`UAM_B_TX_EN];
                next_s.size_hi = wbyte[`UAM_B_SIZE_HI];
                next_s.tx_ninth_bit = wbyte[`UAM_B_TX_NINTH];
            end
            `UAM_OFS_SHARED:
            begin
                if (wbyte[`UAM_SH_SELECT])
                begin
                    next_s.frame_cfg = wbyte[6:0];
                end
                else
                begin
                    next_s.baud_div_high = wbyte[3:0];
                end
            end
            `UAM_OFS_BAUD_LO:
            begin
                next_s.baud_low = wbyte;
            end
            `UAM_OFS_DATA:
            begin
                // writes while the holding buffer is full are dropped
                if (!s.tx_full)
                begin
                    next_s.tx_buf = {s.tx_ninth_bit, wbyte};
                    next_s.tx_full = 1'b1;
                end
            end
            default:
            begin
            end
        endcase
    end
    // reading the data empties the buffer and its status
    if (acc && !pwrite_i && paddr_i == `UAM_OFS_DATA)
    begin
        next_s.rx_complete_flag = 1'b0;
        next_s.frm_err = 1'b0;
        next_s.par_err = 1'b0;
        next_s.overrun = 1'b0;
    end
    if (txc_service_i)
    begin
        next_s.tx_complete_flag = 1'b0;
    end

    // transmitter never looks at the filter bit
    unique case (s.tx_state)
        uam_pkg::TX_IDLE:
        begin
            if (s.tx_full && s.tx_en)
            begin
                next_s.txd = tx_frame[0];
                next_s.tx_shift = {1'b1, tx_frame[12:1]};
                next_s.tx_left = 4'(data_bits + {3'h0, par_en} + 4'h1 + {3'h0, s.frame_cfg[`UAM_FC_TWO_STOP]});
                next_s.tx_samp = 5'h00;
                next_s.tx_full = 1'b0;
                next_s.tx_state = uam_pkg::TX_SHIFT;
            end
        end
        uam_pkg::TX_SHIFT:
        begin
            if (s.tick)
            begin
                next_s.tx_samp = 5'(s.tx_samp + 5'h01);
                if (s.tx_samp == 5'(spb - 5'h01))
                begin
                    next_s.tx_samp = 5'h00;
                    if (s.tx_left == 4'h0)
                    begin
                        next_s.txd = 1'b1;
                        next_s.tx_state = uam_pkg::TX_IDLE;
                        // done only when nothing waits behind this frame
                        if (!next_s.tx_full)
                        begin
                            next_s.tx_complete_flag = 1'b1;
                        end
                    end
                    else
                    begin
                        next_s.txd = s.tx_shift[0];
                        next_s.tx_shift = {1'b1, s.tx_shift[12:1]};
                        next_s.tx_left = 4'(s.tx_left - 4'h1);
                    end
                end
            end
        end
    endcase

    if (s.tick)
    begin
        next_s.rx_prev = s.rxd_sync;
    end
    if (!s.rx_en)
    begin
        // disabling the receiver flushes it at once
        next_s.rx_state = uam_pkg::RX_IDLE;
        next_s.rx_complete_flag = 1'b0;
        next_s.frm_err = 1'b0;
        next_s.par_err = 1'b0;
        next_s.overrun = 1'b0;
    end
    else
    begin
        unique case (s.rx_state)
            uam_pkg::RX_IDLE:
            begin
                // falling edge seen at a tick is sample 1
                if (s.tick && s.rx_prev && !s.rxd_sync)
                begin
                    samp_start = 1'b1;
                    next_s.rx_state = uam_pkg::RX_START;
                end
            end
            uam_pkg::RX_START:
            begin
                // a high start vote is a false start and returns to idle
                if (vote_stb)
                begin
                    next_s.rx_state = vote ? uam_pkg::RX_IDLE : uam_pkg::RX_DATA;
                    next_s.rx_idx = 4'h0;
                    next_s.rx_shift = 9'h000;
                end
            end
            uam_pkg::RX_DATA:
            begin
                if (vote_stb)
                begin
                    next_s.rx_shift[s.rx_idx] = vote;
                    next_s.rx_idx = 4'(s.rx_idx + 4'h1);
                    if (s.rx_idx == 4'(data_bits - 4'h1))
                    begin
                        next_s.rx_state = par_en ? uam_pkg::RX_PAR : uam_pkg::RX_STOP;
                    end
                end
            end
            uam_pkg::RX_PAR:
            begin
                if (vote_stb)
                begin
                    next_s.rx_par = vote;
                    next_s.rx_state = uam_pkg::RX_STOP;
                end
            end
            uam_pkg::RX_STOP:
            begin
                if (vote_stb)
                begin
                    // only the first stop bit is looked at
                    next_s.rx_state = uam_pkg::RX_IDLE;
                    frame_type = nine_bit ? s.rx_shift[8] : vote;
                    // data frames vanish under the filter
                    if (!(s.addr_filter_en && !frame_type))
                    begin
                        // address or unfiltered frame is stored, unless one is still unread, which sets overrun
                        if (next_s.rx_complete_flag)
                        begin
                            next_s.overrun = 1'b1;
                        end
                        else
                        begin
                            next_s.rx_buf = s.rx_shift;
                            next_s.rx_complete_flag = 1'b1;
                            next_s.frm_err = ~vote;
                            next_s.par_err = par_en & (rx_par_calc != s.rx_par);
                        end
                    end
                end
            end
            default:
            begin
                next_s.rx_state = uam_pkg::RX_IDLE;
            end
        endcase
    end
end

always_ff @(posedge clock_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        s <= '0;
        s.rxd_meta <= 1'b1;
        s.rxd_sync <= 1'b1;
        s.rx_prev <= 1'b1;
        s.txd <= 1'b1;
        s.frame_cfg <= `UAM_RST_FRAME_CFG;
    end
    else if (ce_i)
    begin
        s <= next_s;
    end
end

assign prdata_o = s.prdata;
assign pready_o = 1'b1;
assign pslverr_o = acc & ~addr_ok;
assign txd_o = s.txd;

endmodule
`default_nettype wire

//--- design/uam_map.svh
`ifndef UAM_MAP_SVH
`define UAM_MAP_SVH

// register byte offsets
`define UAM_OFS_CSA 8'h00
`define UAM_OFS_CSB 8'h04
`define UAM_OFS_SHARED 8'h08
`define UAM_OFS_BAUD_LO 8'h0C
`define UAM_OFS_DATA 8'h10

// ctrl_status_a fields
`define UAM_A_RX_DONE 7
`define UAM_A_TX_DONE 6
`define UAM_A_TX_EMPTY 5
`define UAM_A_FRM_ERR 4
`define UAM_A_OVERRUN 3
`define UAM_A_PAR_ERR 2
`define UAM_A_DBL 1
`define UAM_A_FILTER 0

// ctrl_status_b fields
`define UAM_B_RXIE 7
`define UAM_B_TXIE 6
`define UAM_B_EMPTYIE 5
`define UAM_B_RX_EN 4
`define UAM_B_TX_EN 3
`define UAM_B_SIZE_HI 2
`define UAM_B_RX_NINTH 1
`define UAM_B_TX_NINTH 0

// shared location: selector and frame configuration fields
`define UAM_SH_SELECT 7
`define UAM_FC_SYNC 6
`define UAM_FC_PAR_EN 5
`define UAM_FC_PAR_ODD 4
`define UAM_FC_TWO_STOP 3
`define UAM_FC_SIZE_HI 2
`define UAM_FC_SIZE_LO 1
`define UAM_FC_POL 0

// reset value and nine-bit size code
`define UAM_RST_FRAME_CFG 7'h06
`define UAM_RST_NINE_CODE 3'h7

// oversampling: samples per bit and first vote sample
`define UAM_SPB_NORM 5'h10
`define UAM_SPB_DBL 5'h08
`define UAM_SF_NORM 5'h08
`define UAM_SF_DBL 5'h04

`endif

//--- design/uam_pkg.sv
package uam_pkg;

typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uam_rx_state_t;
typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} uam_tx_state_t;

typedef struct packed {
    logic [4:0] cnt;
    logic [2:0] win;
    logic stb;
    logic vote;
} uam_smp_state_t;

typedef struct packed {
    logic rxd_meta;
    logic rxd_sync;
    logic rx_prev;
    logic [11:0] baud_cnt;
    logic tick;
    logic [7:0] baud_low;
    logic [3:0] baud_div_high;
    logic [6:0] frame_cfg;
    logic rxie;
    logic txie;
    logic emptyie;
    logic rx_en;
    logic tx_en;
    logic size_hi;
    logic tx_ninth_bit;
    logic rx_complete_flag;
    logic tx_complete_flag;
    logic frm_err;
    logic overrun;
    logic par_err;
    logic double_speed_sel;
    logic addr_filter_en;
    logic [8:0] rx_buf;
    uam_rx_state_t rx_state;
    logic [3:0] rx_idx;
    logic [8:0] rx_shift;
    logic rx_par;
    logic [8:0] tx_buf;
    logic tx_full;
    uam_tx_state_t tx_state;
    logic [12:0] tx_shift;
    logic [3:0] tx_left;
    logic [4:0] tx_samp;
    logic txd;
    logic shared_rd_prev;
    logic [31:0] prdata;
} uam_state_t;

endpackage

//--- design/uam_rx_sampler.sv
`timescale 1ns/1ps
`default_nettype none
`include "uam_map.svh"

module uam_rx_sampler (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic double_speed_i,
    input wire logic rxd_i,
    output logic vote_stb_o,
    output logic vote_o
);

uam_pkg::uam_smp_state_t s;
uam_pkg::uam_smp_state_t next_s;
logic [4:0] spb;
logic [4:0] sf;
logic [4:0] nxt;
logic [2:0] w;

always_comb
begin
    next_s = s;
    next_s.stb = 1'b0;
    spb = double_speed_i ? `UAM_SPB_DBL : `UAM_SPB_NORM;
    sf = double_speed_i ? `UAM_SF_DBL : `UAM_SF_NORM;
    nxt = (s.cnt == spb) ? 5'h01 : 5'(s.cnt + 5'h01);
    w = {s.win[1:0], rxd_i};
    if (start_i)
    begin
        // the detecting sample is sample 1
        next_s.cnt = 5'h01;
        next_s.win = 3'h0;
    end
    else if (tick_i)
    begin
        next_s.cnt = nxt;
        if (nxt >= sf && nxt <= 5'(sf + 5'h02))
        begin
            next_s.win = w;
        end
        if (nxt == 5'(sf + 5'h02))
        begin
            next_s.stb = 1'b1;
            next_s.vote = (w[0] & w[1]) | (w[0] & w[2]) | (w[1] & w[2]);
        end
    end
end

always_ff @(posedge clock_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        s <= '0;
    end
    else if (ce_i)
    begin
        s <= next_s;
    end
end

assign vote_stb_o = s.stb;
assign vote_o = s.vote;

endmodule
`default_nettype wire

//--- tb/uam_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module uam_checker (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic rxd_i,
    input wire logic txd_o,
    input wire logic txc_service_i
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    logic acc;
    logic map_ok;
    logic sh_rd;
    logic rd_setup;
    assign acc = psel_i & penable_i & ce_i;
    assign map_ok = paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    assign sh_rd = psel_i & !pwrite_i & (paddr_i == 8'h08);
    assign rd_setup = psel_i & !penable_i & !pwrite_i & ce_i;
    // zero wait states
    chk_ready_high: assert property (pready_o)
        else $error("ready low");
    chk_unmapped_err: assert property (acc && !map_ok |-> pslverr_o)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (acc && map_ok |-> !pslverr_o)
        else $error("mapped access refused");
    chk_unmapped_zero: assert property (acc && !map_ok && !pwrite_i |-> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    chk_upper_zero: assert property (prdata_o[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_pair_cfg: assert property (acc && sh_rd ##1 rd_setup && sh_rd |=> prdata_o[7])
        else $error("paired read missed frame config");
    chk_lone_high: assert property (rd_setup && sh_rd && !$past(acc && sh_rd) |=> prdata_o[7:4] == 4'h0)
        else $error("lone read not baud high");
    chk_prdata_hold: assert property (!rd_setup |=> $stable(prdata_o))
        else $error("read data moved");
    cov_pair: cover property (acc && sh_rd ##1 rd_setup && sh_rd);
    cov_unmapped: cover property (acc && !map_ok);
    cov_tx_start: cover property (txd_o ##1 !txd_o);
endmodule

bind uam_top uam_checker u_chk (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .rxd_i(rxd_i),
    .txd_o(txd_o),
    .txc_service_i(txc_service_i)
);

`default_nettype wire

//--- tb/uam_node.sv
`timescale 1ns/1ps
`default_nettype none

module uam_node (
    input wire logic clock_i,
    output logic line_o
);
    initial line_o = 1'b1;
    // type as ninth bit or first of two stops, same wave
    task automatic send(input logic [7:0] d, input logic kind, input int per);
        logic [10:0] f;
        f = {1'b1, kind, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            line_o <= f[i];
            repeat (per) @(posedge clock_i);
        end
    endtask
endmodule

`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x, m) begin tests_run++; if ((g) !== (x)) begin error_cnt++; \
    $display("BAD t=%0t %s got %h exp %h", $time, m, g, x); end end

module tb_top;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic ce_i = 1'b1;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic txc_service_i = 1'b0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic rxd_i;
    logic txd_o;
    int error_cnt = 0;
    int tests_run = 0;
    int pers[6] = '{64, 66, 62, 32, 33, 31};
    int exp_q[$];
    logic [31:0] v;
    logic [10:0] bits;

    always #25 clock_i = ~clock_i;

    uam_node u_node (.clock_i(clock_i), .line_o(rxd_i));

    uam_top uut (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .rxd_i(rxd_i),
        .txd_o(txd_o),
        .txc_service_i(txc_service_i)
    );

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // shared pair back to back
    // keep holds psel so a second read follows with no idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic keep,
                       output logic [31:0] r, output logic e);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        // only the watchdog ends a wait for ready
        do
        begin
            @(posedge clock_i);
        end
        while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        if (!keep)
        begin
            psel_i <= 1'b0;
            penable_i <= 1'b0;
            @(posedge clock_i);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, 1'b0, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic keep);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, keep, r, e);
        `CHK({e, r}, {!(a inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}), x}, "read")
    endtask

    // frames the filter should pass are queued as expected bytes
    task automatic frame(input logic [7:0] d, input logic kind, input int per, input logic acc);
        u_node.send(d, kind, per);
        if (acc)
            exp_q.push_back(d);
    endtask

    initial
    begin
        repeat (40000) @(posedge clock_i);
        error_cnt++;
        $display("BAD t=%0t watchdog expired", $time);
        conclude();
    end

    initial
    begin
        void'($urandom(32'h50F1));
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i);
        rd(8'h00, 32'h20, 1'b0);
        rd(8'h04, 32'h00, 1'b0);
        rd(8'h08, 32'h00, 1'b1);
        rd(8'h08, 32'h86, 1'b0);
        v = {28'h0, 4'($urandom)};
        wr(8'h08, v);
        wr(8'h08, 32'h8E);
        rd(8'h08, v, 1'b1);
        rd(8'h08, 32'h8E, 1'b0);
        rd(8'h08, v, 1'b0);
        wr(8'h14, 32'hFF);
        rd(8'h14, 32'h0, 1'b0);
        wr(8'h00, 32'h01);
        rd(8'h00, 32'h21, 1'b0);
        // frozen clock enable drops the write
        ce_i <= 1'b0;
        wr(8'h0C, 32'h5A);
        ce_i <= 1'b1;
        rd(8'h0C, 32'h00, 1'b0);
        wr(8'h08, 32'h00);
        wr(8'h0C, 32'h03);
        wr(8'h04, 32'h18);
        // divisor writes do not reload: the count from the random high four bits must run out
        repeat (4096) @(posedge clock_i);
        $display("test registers done");
        for (int i = 0; i < 6; i++)
        begin
            v = 32'h21 | (i >= 3 ? 32'h2 : 32'h0);
            wr(8'h00, v & 32'h3);
            frame(8'($urandom), 1'b0, pers[i], 1'b0);
            rd(8'h00, v, 1'b0);
            frame(8'($urandom), 1'b1, pers[i], 1'b1);
            rd(8'h00, v | 32'h80, 1'b0);
            rd(8'h10, exp_q.pop_front(), 1'b0);
        end
        $display("test rate and filter done");
        wr(8'h04, 32'h1C);
        wr(8'h00, 32'h01);
        frame(8'($urandom), 1'b0, 64, 1'b0);
        rd(8'h00, 32'h21, 1'b0);
        frame(8'($urandom), 1'b1, 64, 1'b1);
        rd(8'h04, 32'h1E, 1'b0);
        rd(8'h10, exp_q.pop_front(), 1'b0);
        wr(8'h00, 32'h00);
        frame(8'($urandom), 1'b0, 64, 1'b1);
        rd(8'h04, 32'h1C, 1'b0);
        rd(8'h10, exp_q.pop_front(), 1'b0);
        $display("test nine bit done");
        wr(8'h00, 32'h01);
        wr(8'h04, 32'h1D);
        wr(8'h10, 32'h5A);
        for (int n = 0; n < 300 && txd_o !== 1'b0; n++)
            @(posedge clock_i);
        repeat (32) @(posedge clock_i);
        for (int i = 0; i < 11; i++)
        begin
            bits[i] = txd_o;
            repeat (64) @(posedge clock_i);
        end
        `CHK(bits, {2'b11, 8'h5A, 1'b0}, "tx frame")
        repeat (80) @(posedge clock_i);
        rd(8'h00, 32'h61, 1'b0);
        txc_service_i <= 1'b1;
        @(posedge clock_i);
        txc_service_i <= 1'b0;
        @(posedge clock_i);
        rd(8'h00, 32'h21, 1'b0);
        $display("test transmit done");
        conclude();
    end
endmodule

`default_nettype wire
